// File: design/irq_ctl_regs.vh
// register offsets, field positions, reset values and timing counts
// of the interrupt priority and reset control block; definitions only
`ifndef IRQ_CTL_REGS_VH
`define IRQ_CTL_REGS_VH
`define OFS_INT_CONTROL 4'h0
`define OFS_PRIORITY 4'h1
`define OFS_TEST_LO 4'h2
`define OFS_TEST_MID 4'h3
`define OFS_TEST_HI 4'h4
`define OFS_WDOG_CTRL 4'h5
`define OFS_WDOG_SERVICE 4'h6
`define OFS_RESET_STATUS 4'h7
`define OFS_PERIODIC 4'h8
`define OFS_TEST_TOP 4'h9
`define BIT_EDGE_SELECT 7
`define BIT_PIN_CONNECT 6
`define BIT_STOP_DELAY 5
`define PRIORITY_RESET 8'hf2
`define PRIORITY_IRQ 8'hf2
`define PRIORITY_LOWEST 8'hb6
`define VECTOR_RESET 16'hfffe
`define VECTOR_CLOCK_FAIL 16'hfffc
`define VECTOR_WATCHDOG 16'hfffa
`define VECTOR_NMI 16'hfff4
`define SERVICE_FIRST 8'h55
`define SERVICE_SECOND 8'haa
`define RATE_LONGEST 3'h7
`define STOP_DELAY_CYCLES 4096
`define CLOCK_FAIL_DELAY_CYCLES 4096
`define RECOVERY_DRIVE_CYCLES 13'h10
`define SAMPLE_WAIT_CYCLES 13'h9
`define WDOG_BASE_CYCLES 16
`define MODE_NORMAL 1'b0
`endif

// File: design/interrupt_priority_reset_control.v
// interrupt sensing, priority resolution, test forcing, watchdog and reset sequencing
// assumes a single 100 MHz clock, synchronous pins, the core acting on the outputs
`timescale 1ns/100ps
// Function
// R1: edge select 1 takes falling edges of the interrupt pin, 0 takes low level.
// R2: edge select writes once in normal modes; special modes drop first write.
// R3: pin connect bit routes the interrupt pin into the logic; always writable.
// R4: stop exit delay bit imposes about 4096 crystal cycles before resuming.
// R5: stop exit delay bit writable once in normal modes, freely in special.
// R6: priority select register accepts writes only while I mask is one.
// R7: written vector low byte elevates that source; bit 7 reads one, bit 0 zero.
// R8: unimplemented or non-maskable value makes the interrupt pin highest priority.
// R9: reset loads priority f2, level sensing, and sets both masks.
// R10: special-mode test bits force vectors b6..f4 and show arriving requests.
// R11: test registers written only in special mode; normal reads return zero.
// R12: power-on and pin reset share a vector; watchdog and clock fail own ones.
// R13: reset entry needs no clock; leaving reset needs the clock running.
// R14: internal reset drives the reset pin low 16 to 17 cycles then releases.
// R15: nine cycles after release sample pin: low external, high internal.
// R16: clock failure holds pin low through a 4096 cycle delay first.
// R17: external circuitry holds reset at least 32, or 4096 plus 32, cycles.
// R18: watchdog restarts on 55 then aa; any other value resets.
// R19: windowed watchdog accepts service only in the last quarter of period.
// R20: enabled clock monitor resets when the clock drops too slow.
// R21: reset enables watchdog at longest rate, disables monitor, clears periodic bits.
// R22: stacking places return, y, x, b:a and condition codes at sp-2..sp-9.
// R23: after stacking set I, and X when nmi pending; fetch captured vector.
// R24: simultaneous unelevated maskable requests resolve to the higher vector.
`include "irq_ctl_regs.vh"
module interrupt_priority_reset_control #(
  parameter STOP_DELAY = `STOP_DELAY_CYCLES,
  parameter CLOCK_FAIL_DELAY = `CLOCK_FAIL_DELAY_CYCLES,
  parameter WDOG_BASE = `WDOG_BASE_CYCLES
) (
  input wire clock,
  input wire rst_n,
  input wire special_mode,
  input wire [3:0] address,
  input wire [7:0] write_data,
  input wire write_strobe,
  input wire read_strobe,
  output reg [7:0] read_data,
  input wire external_interrupt_pin,
  input wire nonmaskable_interrupt_pin,
  input wire [31:0] module_requests,
  input wire i_mask,
  input wire clock_too_slow,
  input wire stop_exit,
  input wire reset_pin_in,
  output wire reset_pin_out,
  output wire reset_pin_oe,
  output wire core_reset,
  output reg [15:0] reset_vector,
  output wire irq_request,
  output reg [7:0] irq_vector_low,
  input wire stack_start,
  input wire [15:0] stack_pointer,
  output reg [15:0] stack_return_addr,
  output reg [15:0] stack_y_addr,
  output reg [15:0] stack_x_addr,
  output reg [15:0] stack_ab_addr,
  output reg [15:0] stack_ccr_addr,
  output reg set_i_mask,
  output reg set_x_mask,
  output reg [7:0] fetch_vector_low,
  output wire resume_ready
);
  // ************************************************
  // sized constants and reset scope
  // ************************************************
  localparam [7:0] PRIO_RESET_VALUE = `PRIORITY_RESET;
  localparam [15:0] NMI_VECTOR = `VECTOR_NMI;
  // internal resets clear the registers as power-on does;
  // the sequencer itself answers only to the reset input
  wire reg_reset;
  // ************************************************
  // control registers
  // ************************************************
  reg edge_select;
  reg pin_connect;
  reg stop_delay_enable;
  reg edge_written;
  reg delay_written;
  reg special_first_seen;
  reg [6:1] priority_sel;
  reg [31:0] test_force;
  reg wdog_enable;
  reg wdog_window;
  reg monitor_enable;
  reg [2:0] rate_select;
  reg periodic_flag;
  reg [2:0] periodic_rate;
  reg service_armed;
  // starts at the idle level of the pin, so no false edge follows reset
  reg pin_prev;
  reg [31:0] periodic_count;
  wire periodic_tick = periodic_rate != 3'h0 && periodic_count == 32'h0;
  // edge and delay keep separate write-once latches
  wire wr_control = write_strobe && address == `OFS_INT_CONTROL;
  always @(posedge clock) begin
    if (reg_reset) begin
      edge_select <= 1'b0; // [R9]
      pin_connect <= 1'b1;
      stop_delay_enable <= 1'b1; // [R21]
      edge_written <= 1'b0;
      delay_written <= 1'b0;
      special_first_seen <= 1'b0;
      priority_sel <= PRIO_RESET_VALUE[6:1]; // [R9]
      test_force <= 32'h00000000;
      wdog_enable <= 1'b1; // [R21]
      wdog_window <= 1'b0;
      monitor_enable <= 1'b0;
      rate_select <= `RATE_LONGEST;
      periodic_flag <= 1'b0;
      periodic_rate <= 3'h0;
      pin_prev <= 1'b1;
    end else begin
      pin_prev <= external_interrupt_pin;
      if (wr_control) begin
        pin_connect <= write_data[`BIT_PIN_CONNECT]; // [R3]
        if (special_mode == `MODE_NORMAL) begin
          if (!edge_written) edge_select <= write_data[`BIT_EDGE_SELECT]; // [R2]
          if (!delay_written) stop_delay_enable <= write_data[`BIT_STOP_DELAY]; // [R5]
          edge_written <= 1'b1;
          delay_written <= 1'b1;
        end else begin
          special_first_seen <= 1'b1;
          if (special_first_seen) edge_select <= write_data[`BIT_EDGE_SELECT]; // [R2]
          stop_delay_enable <= write_data[`BIT_STOP_DELAY]; // [R5]
        end
      end
      // silently dropped while interrupts are unmasked
      if (write_strobe && address == `OFS_PRIORITY && i_mask)
        priority_sel <= write_data[6:1]; // [R6]
      if (write_strobe && special_mode) begin // [R11]
        case (address)
          `OFS_TEST_LO: test_force[7:0] <= write_data;
          `OFS_TEST_MID: test_force[15:8] <= write_data;
          `OFS_TEST_HI: test_force[23:16] <= write_data;
          `OFS_TEST_TOP: test_force[31:24] <= write_data; // [R10]
          default: test_force <= test_force;
        endcase
      end
      if (write_strobe && address == `OFS_WDOG_CTRL) begin
        rate_select <= write_data[2:0];
        wdog_enable <= write_data[2:0] != 3'h0;
        wdog_window <= write_data[3];
        monitor_enable <= write_data[4];
      end
      if (write_strobe && address == `OFS_PERIODIC) begin
        periodic_rate <= write_data[2:0];
        if (write_data[7]) periodic_flag <= 1'b0;
      end
      if (periodic_tick) periodic_flag <= 1'b1; // set wins over a clear
    end
  end
  // ************************************************
  // interrupt sensing
  // ************************************************
  // source n has vector low byte b6 + 2n; slot 30 (f2) is the pin
  wire pin_fall = pin_prev && !external_interrupt_pin;
  wire pin_active = pin_connect && (edge_select ? pin_fall : !external_interrupt_pin); // [R1][R3]
  reg pin_latched;
  always @(posedge clock) begin
    if (reg_reset) pin_latched <= 1'b0;
    // a new edge beside the acknowledge is kept, not lost
    else if (pin_active && edge_select) pin_latched <= 1'b1;
    else if (stack_start) pin_latched <= 1'b0;
  end
  wire pin_req = edge_select ? pin_latched : pin_active;
  // bit 31 is the non-maskable slot, reachable only by forcing
  wire [31:0] pending = {1'b0, pin_req, module_requests[29:0]} | test_force; // [R10]
  // ************************************************
  // priority resolution
  // ************************************************
  wire [7:0] sel_byte = {1'b1, priority_sel, 1'b0}; // [R7]
  // values below the lowest source are unimplemented and fall back to the pin
  wire sel_valid = sel_byte >= `PRIORITY_LOWEST && sel_byte <= `PRIORITY_IRQ; // [R8]
  wire [7:0] elevated = sel_valid ? sel_byte : `PRIORITY_IRQ; // [R8]
  wire [4:0] elev_idx = elevated[5:1] - 5'h1b; // b6>>1 = 5b
  reg [7:0] winner;
  reg found;
  integer k;
  always @* begin
    winner = 8'h00;
    found = 1'b0;
    for (k = 0; k < 31; k = k + 1)
      if (pending[k]) begin // [R24]
        winner = `PRIORITY_LOWEST + {k[6:0], 1'b0};
        found = 1'b1;
      end
    if (pending[elev_idx]) winner = elevated;
  end
  // the I bit masks only the request, never the priority choice
  assign irq_request = found && !i_mask;
  wire nmi_pending = !nonmaskable_interrupt_pin || test_force[31]; // [R10]
  // ************************************************
  // stacking and vector fetch
  // ************************************************
  always @(posedge clock) begin
    if (reg_reset) begin
      irq_vector_low <= 8'h00;
      stack_return_addr <= 16'h0000;
      stack_y_addr <= 16'h0000;
      stack_x_addr <= 16'h0000;
      stack_ab_addr <= 16'h0000;
      stack_ccr_addr <= 16'h0000;
      set_i_mask <= 1'b1; // [R9]
      set_x_mask <= 1'b1;
      fetch_vector_low <= 8'h00;
    end else begin
      irq_vector_low <= winner;
      set_i_mask <= 1'b0;
      set_x_mask <= 1'b0;
      if (stack_start) begin
        stack_return_addr <= stack_pointer - 16'h2; // [R22]
        stack_y_addr <= stack_pointer - 16'h4;
        stack_x_addr <= stack_pointer - 16'h6;
        stack_ab_addr <= stack_pointer - 16'h8;
        stack_ccr_addr <= stack_pointer - 16'h9;
        set_i_mask <= 1'b1; // [R23]
        set_x_mask <= nmi_pending;
        // winner as it stood when stacking began
        fetch_vector_low <= nmi_pending ? NMI_VECTOR[7:0] : winner; // [R23]
      end
    end
  end
  // ************************************************
  // watchdog
  // ************************************************
  reg [31:0] wdog_count;
  wire [31:0] wdog_period = WDOG_BASE << {rate_select, 1'b0};
  wire wr_service = write_strobe && address == `OFS_WDOG_SERVICE;
  // any value but the two keys counts as a failure
  reg wdog_fail;
  always @(posedge clock) begin
    if (reg_reset) begin
      wdog_count <= 32'h0;
      service_armed <= 1'b0;
      wdog_fail <= 1'b0;
    end else begin
      wdog_fail <= 1'b0;
      // a disabled watchdog restarts from zero once enabled again
      wdog_count <= wdog_enable ? wdog_count + 32'h1 : 32'h0;
      if (wdog_enable && wdog_count >= wdog_period) wdog_fail <= 1'b1; // [R18]
      if (wdog_enable && wr_service) begin
        // a premature write fails the part rather than being ignored
        if (wdog_window && wdog_count < wdog_period - (wdog_period >> 2))
          wdog_fail <= 1'b1; // [R19]
        else if (write_data == `SERVICE_FIRST) service_armed <= 1'b1;
        else if (write_data == `SERVICE_SECOND && service_armed) begin
          service_armed <= 1'b0;
          wdog_count <= 32'h0; // [R18]
        end else wdog_fail <= 1'b1; // [R18]
      end
    end
  end
  // ************************************************
  // clock monitor and stop delay
  // ************************************************
  wire clock_fail = monitor_enable && clock_too_slow; // [R20]
  // counted on this clock; the crystal rate sets the real time
  reg [12:0] stop_count;
  always @(posedge clock) begin
    if (reg_reset) stop_count <= 13'h0;
    else if (stop_exit && stop_delay_enable) stop_count <= STOP_DELAY[12:0]; // [R4]
    else if (stop_count != 13'h0) stop_count <= stop_count - 13'h1;
  end
  assign resume_ready = stop_count == 13'h0;
  // ************************************************
  // periodic tick
  // ************************************************
  // only flag and rate live here; rate 0 stops the tick
  always @(posedge clock) begin
    if (reg_reset || periodic_count == 32'h0)
      periodic_count <= WDOG_BASE << {periodic_rate, 1'b0};
    else
      periodic_count <= periodic_count - 32'h1;
  end
  // ************************************************
  // reset sequencer
  // ************************************************
  localparam S_IDLE = 3'h0;
  localparam S_OSC = 3'h1;
  localparam S_DRIVE = 3'h2;
  localparam S_WAIT = 3'h3;
  localparam S_RUN = 3'h4;
  reg [2:0] state;
  reg [12:0] seq_count;
  reg [1:0] cause; // 0 por/pin, 1 watchdog, 2 clock
  // the block is held while the pin is driven or awaiting its sample
  assign reg_reset = !rst_n || (state != S_IDLE && state != S_RUN);
  always @(posedge clock) begin
    if (!rst_n) begin
      state <= S_IDLE;
      seq_count <= 13'h0;
      cause <= 2'h0;
      reset_vector <= `VECTOR_RESET;
    end else begin
      case (state)
        S_IDLE: begin
          // clock failure outranks a watchdog failure in the same cycle
          if (clock_fail) begin
            state <= S_OSC; // [R16]
            cause <= 2'h2;
            seq_count <= CLOCK_FAIL_DELAY[12:0];
          end else if (wdog_fail) begin
            state <= S_DRIVE; // [R14]
            cause <= 2'h1;
            seq_count <= `RECOVERY_DRIVE_CYCLES;
          end else if (!reset_pin_in) begin
            state <= S_DRIVE;
            cause <= 2'h0;
            seq_count <= `RECOVERY_DRIVE_CYCLES;
          end
        end
        S_OSC: begin
          seq_count <= seq_count - 13'h1;
          if (seq_count == 13'h1) begin
            state <= S_DRIVE;
            seq_count <= `RECOVERY_DRIVE_CYCLES;
          end
        end
        S_DRIVE: begin
          seq_count <= seq_count - 13'h1;
          if (seq_count == 13'h1) begin
            state <= S_WAIT;
            seq_count <= `SAMPLE_WAIT_CYCLES;
          end
        end
        S_WAIT: begin
          seq_count <= seq_count - 13'h1;
          // the pin is sampled on the last wait cycle
          if (seq_count == 13'h1) begin
            state <= S_RUN;
            if (!reset_pin_in) reset_vector <= `VECTOR_RESET; // [R15][R12]
            else if (cause == 2'h2) reset_vector <= `VECTOR_CLOCK_FAIL;
            else reset_vector <= `VECTOR_WATCHDOG;
          end
        end
        S_RUN: begin
          // an outside hold on the pin must end first, or it starts a new sequence
          if (reset_pin_in) state <= S_IDLE;
        end
        default: state <= S_IDLE;
      endcase
    end
  end
  // internal drive only, the pin itself is an open-drain wire
  assign reset_pin_out = 1'b0;
  assign reset_pin_oe = state == S_OSC || state == S_DRIVE; // [R14][R16]
  // [R13] entry gated directly by rst_n; exit is clocked by the sequencer
  assign core_reset = !rst_n || (state != S_IDLE && state != S_RUN);
  // ************************************************
  // register read port
  // ************************************************
  // a test read while a request changes may catch either value
  always @(posedge clock) begin
    if (!rst_n) read_data <= 8'h00;
    else if (read_strobe) begin
      case (address)
        `OFS_INT_CONTROL: read_data <= {edge_select, pin_connect, stop_delay_enable, 5'h00};
        `OFS_PRIORITY: read_data <= sel_byte; // [R7]
        `OFS_TEST_LO: read_data <= special_mode ? pending[7:0] : 8'h00; // [R11]
        `OFS_TEST_MID: read_data <= special_mode ? pending[15:8] : 8'h00;
        `OFS_TEST_HI: read_data <= special_mode ? pending[23:16] : 8'h00;
        `OFS_TEST_TOP: read_data <= special_mode ? pending[31:24] : 8'h00;
        `OFS_WDOG_CTRL: read_data <= {3'h0, monitor_enable, wdog_window, rate_select};
        `OFS_RESET_STATUS: read_data <= {5'h00, state};
        `OFS_PERIODIC: read_data <= {periodic_flag, 4'h0, periodic_rate};
        default: read_data <= 8'h00;
      endcase
    end
  end
endmodule // interrupt_priority_reset_control

// File: test/interrupt_priority_reset_control_sva.sv
// port checker of the interrupt priority and reset control block
// assumes the register header on the include path; bound onto the design below
`timescale 1ns/100ps
`include "irq_ctl_regs.vh"
module irq_ctl_checker #(
  parameter CLOCK_FAIL_DELAY = 8
) (
  input wire clock,
  input wire rst_n,
  input wire special_mode,
  input wire [3:0] address,
  input wire read_strobe,
  input wire [7:0] read_data,
  input wire nonmaskable_interrupt_pin,
  input wire reset_pin_in,
  input wire reset_pin_out,
  input wire reset_pin_oe,
  input wire [15:0] reset_vector,
  input wire stack_start,
  input wire [15:0] stack_pointer,
  input wire [15:0] stack_return_addr,
  input wire [15:0] stack_y_addr,
  input wire [15:0] stack_x_addr,
  input wire [15:0] stack_ab_addr,
  input wire [15:0] stack_ccr_addr,
  input wire set_i_mask,
  input wire set_x_mask
);
  // ************************
  // helper logic
  // ************************
  reg [15:0] drive_cnt;
  reg drive_armed;
  reg [15:0] sp_d;
  // a drive already running at reset release is not measured
  always @(posedge clock) begin
    sp_d <= stack_pointer;
    if (!rst_n) begin
      drive_cnt <= 16'h0000;
      drive_armed <= 1'b0;
    end else if (reset_pin_oe) begin
      drive_cnt <= drive_cnt + 16'h0001;
    end else begin
      drive_cnt <= 16'h0000;
      drive_armed <= 1'b1;
    end
  end
  // ************************
  // properties
  // ************************
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  sequence prio_read;
    read_strobe && address == `OFS_PRIORITY;
  endsequence
  sequence test_read_normal;
    read_strobe && !special_mode && address >= `OFS_TEST_LO && address <= `OFS_TEST_HI;
  endsequence
  sequence drive_end;
    $fell(reset_pin_oe) && drive_armed;
  endsequence
  chk_prio_fixed_bits: assert property (prio_read |=> read_data[7] && !read_data[0])
    else $error("priority read shows wrong fixed bits");
  chk_test_read_zero: assert property (test_read_normal |=> read_data == 8'h00)
    else $error("test register read in normal mode not zero");
  chk_pin_drive_low: assert property (reset_pin_oe |-> !reset_pin_out)
    else $error("reset pin driven high");
  chk_drive_length: assert property (drive_end |-> (drive_cnt >= 16 && drive_cnt <= 17) ||
    (drive_cnt >= CLOCK_FAIL_DELAY + 16 && drive_cnt <= CLOCK_FAIL_DELAY + 17))
    else $error("reset pin drive length wrong");
  chk_stack_addr: assert property (stack_start |=> stack_return_addr == sp_d - 16'h0002 &&
    stack_y_addr == sp_d - 16'h0004 && stack_x_addr == sp_d - 16'h0006 &&
    stack_ab_addr == sp_d - 16'h0008 && stack_ccr_addr == sp_d - 16'h0009)
    else $error("stacking addresses wrong");
  chk_set_i_mask: assert property (stack_start |=> set_i_mask)
    else $error("I mask not set after stacking");
  chk_set_x_mask: assert property (stack_start && !nonmaskable_interrupt_pin |=> set_x_mask)
    else $error("X mask not set with nmi pending");
  chk_internal_vec: assert property (drive_end ##0 reset_pin_in |-> ##[9:12]
    (reset_vector == `VECTOR_WATCHDOG || reset_vector == `VECTOR_CLOCK_FAIL))
    else $error("internal reset not classified internal");
  chk_external_vec: assert property (drive_end ##0 !reset_pin_in |-> ##[9:12]
    reset_vector == `VECTOR_RESET)
    else $error("external reset not classified external");
endmodule // irq_ctl_checker
bind interrupt_priority_reset_control irq_ctl_checker #(.CLOCK_FAIL_DELAY(CLOCK_FAIL_DELAY)) chk (
  .clock, .rst_n, .special_mode, .address, .read_strobe, .read_data, .nonmaskable_interrupt_pin,
  .reset_pin_in, .reset_pin_out, .reset_pin_oe, .reset_vector, .stack_start, .stack_pointer,
  .stack_return_addr, .stack_y_addr, .stack_x_addr, .stack_ab_addr, .stack_ccr_addr,
  .set_i_mask, .set_x_mask);

// File: test/reset_pin_model.sv
// external reset circuitry on the open-drain reset pin, with pull-up
// assumes ext_req is a request from the bench; every cycle it is high reloads the hold
`timescale 1ns/100ps
module reset_pin_model #(
  parameter HOLD_CYCLES = 40
) (
  input wire clock,
  input wire reset_pin_oe,
  input wire reset_pin_out,
  input wire ext_req,
  output wire reset_pin_in
);
  // ************************
  // pin level
  // ************************
  reg [7:0] hold_left = 8'h00;
  // held past 32 cycles so a watchdog drive is not mistaken for the cause
  always @(posedge clock) begin
    if (ext_req) begin
      hold_left <= HOLD_CYCLES;
    end else if (hold_left != 8'h00) begin
      hold_left <= hold_left - 8'h01;
    end
  end
  assign reset_pin_in = (reset_pin_oe ? reset_pin_out : 1'b1) & (hold_left == 8'h00);
endmodule // reset_pin_model

// File: test/tb_interrupt_priority_reset_control.sv
// self-checking bench of the interrupt priority and reset control block
// assumes the bound checker and the reset pin model
`timescale 1ns/100ps
`include "irq_ctl_regs.vh"
module tb_interrupt_priority_reset_control;
  // ************************
  // signals and instances
  // ************************
  logic clock = 1'b0, rst_n = 1'b0, special_mode = 1'b0, write_strobe = 1'b0, read_strobe = 1'b0;
  logic external_interrupt_pin = 1'b1, nonmaskable_interrupt_pin = 1'b1, i_mask = 1'b1;
  logic clock_too_slow = 1'b0, stop_exit = 1'b0, stack_start = 1'b0, ext_req = 1'b0, rd_flag = 1'b0;
  logic [3:0] address = 4'h0;
  logic [7:0] write_data = 8'h00, pv;
  logic [31:0] module_requests = 32'h0;
  logic [15:0] stack_pointer = 16'h0100, note;
  logic [15:0] exp_q[$];
  wire [7:0] read_data, irq_vector_low;
  wire [15:0] reset_vector, stack_ccr_addr;
  wire reset_pin_in, reset_pin_out, reset_pin_oe, core_reset, irq_request;
  wire set_i_mask, set_x_mask, resume_ready;
  int num_errors = 0, tests_run = 0, n;
  interrupt_priority_reset_control #(.STOP_DELAY(8), .CLOCK_FAIL_DELAY(8), .WDOG_BASE(1)) dut (
    .clock, .rst_n, .special_mode, .address, .write_data, .write_strobe, .read_strobe,
    .read_data, .external_interrupt_pin, .nonmaskable_interrupt_pin, .module_requests,
    .i_mask, .clock_too_slow, .stop_exit, .reset_pin_in, .reset_pin_out, .reset_pin_oe,
    .core_reset, .reset_vector, .irq_request, .irq_vector_low, .stack_start, .stack_pointer,
    .stack_return_addr(), .stack_y_addr(), .stack_x_addr(), .stack_ab_addr(), .stack_ccr_addr,
    .set_i_mask, .set_x_mask, .fetch_vector_low(), .resume_ready);
  reset_pin_model pin (.clock, .reset_pin_oe, .reset_pin_out, .ext_req, .reset_pin_in);
  always #5 clock = ~clock;
  // ************************
  // tasks and read monitor
  // ************************
  task automatic check(input [15:0] seen, input [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic close_out;
    $display("errors=%0d checks=%0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
    @(posedge clock);
    write_strobe <= w;
    read_strobe <= !w;
    address <= a;
    write_data <= d;
    @(posedge clock);
    write_strobe <= 1'b0;
    read_strobe <= 1'b0;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e);
    exp_q.push_back({m, e});
    bus(1'b0, a, 8'h00);
  endtask
  // the fault stimulus is dropped once the pin drive begins
  task automatic wait_seq;
    for (n = 0; n < 400 && !reset_pin_oe; n++)
      @(posedge clock);
    clock_too_slow <= 1'b0;
    for (n = n; n < 400 && (reset_pin_oe || core_reset); n++)
      @(posedge clock);
    if (n == 400) begin
      num_errors++;
      close_out;
    end
    repeat (4) @(posedge clock);
  endtask
  task automatic stop_check(input logic e);
    stop_exit <= 1'b1;
    @(posedge clock);
    stop_exit <= 1'b0;
    repeat (2) @(posedge clock);
    check({15'h0000, resume_ready}, {15'h0000, e});
    repeat (12) @(posedge clock);
    check({15'h0000, resume_ready}, 16'h0001);
  endtask
  always @(posedge clock) begin
    if (rd_flag) begin
      note = exp_q.pop_front();
      check({8'h00, read_data & note[15:8]}, {8'h00, note[7:0]});
    end
    rd_flag <= read_strobe;
  end
  initial begin
    repeat (20000) @(posedge clock);
    num_errors++;
    close_out;
  end
  // ************************
  // main sequence
  // ************************
  initial begin
    pv = $urandom(32'h7a771749);
    repeat (6) @(posedge clock);
    rst_n <= 1'b1;
    rd(`OFS_INT_CONTROL, 8'he0, 8'h60);
    rd(`OFS_PRIORITY, 8'hff, `PRIORITY_RESET);
    rd(`OFS_WDOG_CTRL, 8'h17, {5'h00, `RATE_LONGEST});
    rd(`OFS_TEST_LO, 8'hff, 8'h00);
    module_requests <= 32'h0000_0021;
    repeat (3) @(posedge clock);
    check({8'h00, irq_vector_low}, 16'h00c0);
    pv = 8'hb6 + 8'(2 * ($urandom % 30));
    wr(`OFS_PRIORITY, pv);
    rd(`OFS_PRIORITY, 8'hff, pv);
    wr(`OFS_PRIORITY, `PRIORITY_LOWEST);
    i_mask <= 1'b0;
    wr(`OFS_PRIORITY, 8'hc0);
    rd(`OFS_PRIORITY, 8'hff, `PRIORITY_LOWEST);
    check({8'h00, irq_vector_low}, 16'h00b6);
    i_mask <= 1'b1;
    wr(`OFS_PRIORITY, 8'hf4);
    external_interrupt_pin <= 1'b0;
    repeat (3) @(posedge clock);
    check({8'h00, irq_vector_low}, 16'h00f2);
    module_requests <= 32'h0;
    i_mask <= 1'b0;
    wr(`OFS_INT_CONTROL, 8'h20);
    repeat (2) @(posedge clock);
    check({15'h0000, irq_request}, 16'h0000);
    wr(`OFS_INT_CONTROL, 8'hc0);
    rd(`OFS_INT_CONTROL, 8'he0, 8'h60);
    check({15'h0000, irq_request}, 16'h0001);
    external_interrupt_pin <= 1'b1;
    stop_check(1'b0);
    stack_pointer <= 16'($urandom);
    nonmaskable_interrupt_pin <= 1'b0;
    stack_start <= 1'b1;
    @(posedge clock);
    stack_start <= 1'b0;
    @(negedge clock);
    check(stack_ccr_addr, stack_pointer - 16'h0009);
    check({14'h0000, set_i_mask, set_x_mask}, 16'h0003);
    @(posedge clock);
    nonmaskable_interrupt_pin <= 1'b1;
    special_mode <= 1'b1;
    wr(`OFS_WDOG_SERVICE, `SERVICE_FIRST);
    wr(`OFS_WDOG_SERVICE, `SERVICE_SECOND);
    repeat (4) @(posedge clock);
    check({15'h0000, reset_pin_oe}, 16'h0000);
    wr(`OFS_WDOG_SERVICE, `SERVICE_FIRST);
    wr(`OFS_WDOG_SERVICE, 8'h12);
    wait_seq;
    check(reset_vector, `VECTOR_WATCHDOG);
    rd(`OFS_PRIORITY, 8'hff, `PRIORITY_RESET);
    ext_req <= 1'b1;
    wr(`OFS_WDOG_SERVICE, 8'h12);
    ext_req <= 1'b0;
    wait_seq;
    check(reset_vector, `VECTOR_RESET);
    wr(`OFS_WDOG_CTRL, 8'h17);
    clock_too_slow <= 1'b1;
    wait_seq;
    check(reset_vector, `VECTOR_CLOCK_FAIL);
    wr(`OFS_INT_CONTROL, 8'h80);
    rd(`OFS_INT_CONTROL, 8'ha0, 8'h00);
    wr(`OFS_INT_CONTROL, 8'h80);
    rd(`OFS_INT_CONTROL, 8'ha0, 8'h80);
    stop_check(1'b1);
    module_requests <= 32'h1;
    wr(`OFS_TEST_LO, 8'h02);
    rd(`OFS_TEST_LO, 8'h03, 8'h03);
    check({8'h00, irq_vector_low}, 16'h00b8);
    wr(`OFS_TEST_TOP, 8'h40);
    rd(`OFS_TEST_TOP, 8'hff, 8'h40);
    check({8'h00, irq_vector_low}, 16'h00f2);
    close_out;
  end
endmodule // tb_interrupt_priority_reset_control
